// [rtl/lfs_pkg.sv]
package lfs_pkg;

   // frame identifiers (protected id bytes as seen on the bus)
   localparam logic [7:0] REQ_ID           = 8'h3C;
   localparam logic [7:0] RESP_ID          = 8'h7D;
   localparam logic [7:0] APP_CMD          = 8'h80;
   localparam logic [7:0] FULL_STATUS_CMD  = 8'h81;
   localparam logic [1:0] ADDR_TOP         = 2'h3;
   localparam logic [7:0] FILLER           = 8'hFF;
   localparam logic [7:0] CKSUM_GOOD       = 8'hFF;
   localparam logic [2:0] LAST_DATA_IDX    = 3'h7;

   // led fault codes
   localparam logic [2:0] FAULT_NONE       = 3'h0;
   localparam logic [2:0] FAULT_OPEN_ANODE = 3'h3;
   localparam logic [2:0] FAULT_OPEN_CATH  = 3'h5;
   localparam logic [2:0] FAULT_SHORT_GND  = 3'h2;

   // derating level reported when thermal control is off
   localparam logic [3:0] DERATE_MAX_ON    = 4'hF;

   // apb register offsets
   localparam logic [7:0] CONFIG_OFS       = 8'h00;
   localparam logic [7:0] STATUS_OFS       = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS   = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS     = 8'h0C;

   // config field positions
   localparam int ADDR_LSB                 = 0;
   localparam int GROUP_LSB                = 8;
   localparam int LEDS_ON_BIT              = 12;
   localparam int LED_EN_LSB               = 13;
   localparam int THERM_EN_BIT             = 16;
   localparam logic [31:0] CONFIG_RESET    = 32'h0001_0000;

   // interrupt bits
   localparam int IRQ_SERVED               = 0;
   localparam int IRQ_REJECTED             = 1;
   localparam int IRQ_SENT                 = 2;
   localparam logic [2:0] IRQ_RESET        = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DATA,
      ST_CKSUM,
      ST_BUILD,
      ST_FETCH,
      ST_LOAD,
      ST_OUT,
      ST_CKOUT
   } lfs_state_type;

endpackage : lfs_pkg

// [rtl/lfs_resp_mem.sv]
module lfs_resp_mem (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire logic [2:0] rd_addr,
   output logic      [7:0] rd_data
);

   typedef struct packed {
      logic [7:0][7:0] mem;
      logic [7:0]      rd;
   } lfs_mem_type;

   lfs_mem_type mem_reg;
   lfs_mem_type mem_next;

   always_comb begin
      mem_next = mem_reg;
      if (wr_en) begin
         mem_next.mem[wr_addr] = wr_data;
      end
      mem_next.rd = mem_reg.mem[rd_addr];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_reg <= '0;
      end else if (ce) begin
         mem_reg <= mem_next;
      end
   end

   assign rd_data = mem_reg.rd;

endmodule : lfs_resp_mem

// [rtl/lfs_responder.sv]
// Summary of operation
// - decode only 0x3C eight-byte diagnostic frames
// - reject request on classic checksum mismatch
// - valid request clears latched fault flags
// - persisting faults set flags again immediately
// - response byte one: ones plus address
// - temp info live, warning/shutdown latched
// - per-led three-bit fault codes reported
// - read-only derating level, valid when enabled
// - lin error flags reset when served
// - data, header, bit error combinations
// - respond only on matching node address
//
// Design decisions made here: the APB register port and the register addresses.
module lfs_responder (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        rx_id_valid,
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic      [7:0]  tx_data,
   input  wire logic        temp_warning_cond,
   input  wire logic        thermal_shutdown_cond,
   input  wire logic        supply_reset_event,
   input  wire logic        retry_state_cond,
   input  wire logic        undervoltage,
   input  wire logic [1:0]  temp_info,
   input  wire logic [3:0]  thermal_derating_level,
   input  wire logic [8:0]  led_fault_cond,
   input  wire logic        checksum_err,
   input  wire logic        stopbit_err,
   input  wire logic        length_err,
   input  wire logic        parity_err,
   input  wire logic        sync_err,
   input  wire logic        bit_err
);

   typedef struct packed {
      lfs_pkg::lfs_state_type state;
      logic [2:0]             cnt;
      logic [7:0]             sum;
      logic                   req_ok;
      logic                   pending;
      logic [7:0]             cksum;
      logic                   temp_warning_flag;
      logic                   thermal_shutdown_flag;
      logic                   supply_reset_flag;
      logic                   retry_state_flag;
      logic [8:0]             led_fault_code;
      logic [2:0]             lin_err;
      logic [15:0]            snap;
      logic [31:0]            config_bits;
      logic [2:0]             irq_status;
      logic [2:0]             irq_mask;
      logic [31:0]            rdata;
      logic [7:0]             tx_data;
   } lfs_regs_type;

   lfs_regs_type r_reg;
   lfs_regs_type r_next;

   logic [7:0] mem_rd_data;
   logic       mem_wr_en;
   logic [7:0] mem_wr_data;

   // classic checksum: eight-bit sum with end-around carry
   function automatic logic [7:0] cks_add(input logic [7:0] s,
                                          input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, s} + {1'b0, b};
      return t[7:0] + {7'h00, t[8]};
   endfunction : cks_add

   // byte that a valid request carries at each data position
   function automatic logic [7:0] req_expect(input logic [2:0] idx,
                                             input logic [5:0] addr);
      case (idx)
         3'h0:    return lfs_pkg::APP_CMD;
         3'h1:    return lfs_pkg::FULL_STATUS_CMD;
         3'h2:    return {lfs_pkg::ADDR_TOP, addr};
         default: return lfs_pkg::FILLER;
      endcase
   endfunction : req_expect

   // index zero marks an offset with no register behind it
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      case (a)
         lfs_pkg::CONFIG_OFS:     return 3'h1;
         lfs_pkg::STATUS_OFS:     return 3'h2;
         lfs_pkg::IRQ_STATUS_OFS: return 3'h3;
         lfs_pkg::IRQ_MASK_OFS:   return 3'h4;
         default:                 return 3'h0;
      endcase
   endfunction : reg_index

   wire logic [5:0] node_addr = r_reg.config_bits[lfs_pkg::ADDR_LSB +: 6];
   wire logic       therm_en  = r_reg.config_bits[lfs_pkg::THERM_EN_BIT];
   wire logic [7:0] ctl_byte  = {
      r_reg.config_bits[lfs_pkg::LED_EN_LSB +: 3],
      r_reg.config_bits[lfs_pkg::LEDS_ON_BIT],
      r_reg.config_bits[lfs_pkg::GROUP_LSB +: 4]};

   // snapshot bits: [15:13] lin errs, [12] retry, [11] supply reset,
   // [10] shutdown, [9] warning, [8:0] led codes
   logic [7:0][7:0] frame;
   always_comb begin
      frame[0] = {lfs_pkg::ADDR_TOP, node_addr};
      frame[1] = lfs_pkg::FILLER;
      frame[2] = {5'h1F, r_reg.snap[15:13]};
      frame[3] = {2'h3, undervoltage, r_reg.snap[11], r_reg.snap[10],
                  r_reg.snap[9], temp_info};
      frame[4] = {therm_en ? thermal_derating_level
                           : lfs_pkg::DERATE_MAX_ON,
                  r_reg.snap[12], r_reg.snap[2:0]};
      frame[5] = {1'b1, r_reg.snap[8:6], 1'b1, r_reg.snap[5:3]};
      frame[6] = ctl_byte;
      frame[7] = lfs_pkg::FILLER;
   end

   lfs_resp_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .wr_en   (mem_wr_en),
      .wr_addr (r_reg.cnt),
      .wr_data (mem_wr_data),
      .rd_addr (r_reg.cnt),
      .rd_data (mem_rd_data)
   );

   always_comb begin
      logic       clr;
      logic       own_bad;
      logic [2:0] irq_set;
      logic [2:0] lin_set;
      logic [2:0] idx;
      logic       apb_wr;
      clr         = 1'b0;
      own_bad     = 1'b0;
      irq_set     = 3'h0;
      lin_set     = 3'h0;
      idx         = reg_index(paddr);
      apb_wr      = psel && penable && pwrite;
      mem_wr_en   = 1'b0;
      mem_wr_data = frame[r_reg.cnt];
      r_next      = r_reg;

      case (r_reg.state)
         lfs_pkg::ST_IDLE, lfs_pkg::ST_DATA, lfs_pkg::ST_CKSUM: begin
            if (rx_id_valid) begin
               r_next.cnt    = 3'h0;
               r_next.sum    = 8'h00;
               r_next.req_ok = 1'b1;
               if (rx_byte == lfs_pkg::REQ_ID) begin
                  r_next.state = lfs_pkg::ST_DATA;
               end else if (rx_byte == lfs_pkg::RESP_ID
                            && r_reg.pending) begin
                  r_next.state = lfs_pkg::ST_FETCH;
               end else begin
                  r_next.state = lfs_pkg::ST_IDLE;
               end
            end else if (rx_byte_valid
                         && r_reg.state == lfs_pkg::ST_DATA) begin
               r_next.sum = cks_add(r_reg.sum, rx_byte);
               if (rx_byte != req_expect(r_reg.cnt, node_addr)) begin
                  r_next.req_ok = 1'b0;
               end
               r_next.cnt = r_reg.cnt + 3'h1;
               if (r_reg.cnt == lfs_pkg::LAST_DATA_IDX) begin
                  r_next.state = lfs_pkg::ST_CKSUM;
               end
            end else if (rx_byte_valid
                         && r_reg.state == lfs_pkg::ST_CKSUM) begin
               r_next.state = lfs_pkg::ST_IDLE;
               if (cks_add(r_reg.sum, rx_byte) != lfs_pkg::CKSUM_GOOD)
               begin
                  own_bad = 1'b1;
                  irq_set[lfs_pkg::IRQ_REJECTED] = 1'b1;
               end else if (r_reg.req_ok) begin
                  // a fresh request replaces any unsent response
                  r_next.snap = {r_reg.lin_err, r_reg.retry_state_flag,
                                 r_reg.supply_reset_flag,
                                 r_reg.thermal_shutdown_flag,
                                 r_reg.temp_warning_flag,
                                 r_reg.led_fault_code};
                  clr          = 1'b1;
                  r_next.sum   = 8'h00;
                  r_next.pending = 1'b0;
                  r_next.state = lfs_pkg::ST_BUILD;
                  irq_set[lfs_pkg::IRQ_SERVED] = 1'b1;
               end
            end
         end
         lfs_pkg::ST_BUILD: begin
            // one frame byte a cycle; the checksum is summed alongside
            mem_wr_en  = 1'b1;
            r_next.sum = cks_add(r_reg.sum, frame[r_reg.cnt]);
            r_next.cnt = r_reg.cnt + 3'h1;
            if (r_reg.cnt == lfs_pkg::LAST_DATA_IDX) begin
               r_next.cksum   = ~cks_add(r_reg.sum, frame[r_reg.cnt]);
               r_next.pending = 1'b1;
               r_next.state   = lfs_pkg::ST_IDLE;
            end
         end
         lfs_pkg::ST_FETCH: begin
            // the memory's read register costs one cycle before load
            r_next.state = lfs_pkg::ST_LOAD;
         end
         lfs_pkg::ST_LOAD: begin
            r_next.tx_data = mem_rd_data;
            r_next.state   = lfs_pkg::ST_OUT;
         end
         lfs_pkg::ST_OUT: begin
            // a new header means the master gave up on this response
            if (rx_id_valid) begin
               r_next.state = lfs_pkg::ST_IDLE;
            end else if (tx_ready) begin
               if (r_reg.cnt == lfs_pkg::LAST_DATA_IDX) begin
                  r_next.tx_data = r_reg.cksum;
                  r_next.state   = lfs_pkg::ST_CKOUT;
               end else begin
                  r_next.cnt   = r_reg.cnt + 3'h1;
                  r_next.state = lfs_pkg::ST_FETCH;
               end
            end
         end
         lfs_pkg::ST_CKOUT: begin
            // an abort keeps pending, so the master may ask again
            if (rx_id_valid) begin
               r_next.state = lfs_pkg::ST_IDLE;
            end else if (tx_ready) begin
               r_next.pending = 1'b0;
               r_next.state   = lfs_pkg::ST_IDLE;
               irq_set[lfs_pkg::IRQ_SENT] = 1'b1;
            end
         end
         default: begin
            r_next.state = lfs_pkg::ST_IDLE;
         end
      endcase

      lin_set = {checksum_err | stopbit_err | length_err | own_bad,
                 parity_err | sync_err,
                 bit_err};
      r_next.lin_err = (r_reg.lin_err & {3{~clr}}) | lin_set;
      r_next.temp_warning_flag =
         (r_reg.temp_warning_flag & ~clr) | temp_warning_cond;
      r_next.thermal_shutdown_flag =
         (r_reg.thermal_shutdown_flag & ~clr) | thermal_shutdown_cond;
      r_next.supply_reset_flag =
         (r_reg.supply_reset_flag & ~clr) | supply_reset_event;
      r_next.retry_state_flag =
         (r_reg.retry_state_flag & ~clr) | retry_state_cond;
      // a live nonzero code overwrites; clear only zeros a quiet led
      for (int i = 0; i < 3; i++) begin
         if (led_fault_cond[3*i +: 3] != lfs_pkg::FAULT_NONE) begin
            r_next.led_fault_code[3*i +: 3] = led_fault_cond[3*i +: 3];
         end else if (clr) begin
            r_next.led_fault_code[3*i +: 3] = lfs_pkg::FAULT_NONE;
         end
      end

      // apb: read data is captured in the setup cycle
      if (psel && !penable) begin
         case (idx)
            3'h1:    r_next.rdata = r_reg.config_bits;
            // status word: 12 zero bits above 20 bits of state
            3'h2:    r_next.rdata = {12'h000,
                                     r_reg.state,
                                     r_reg.pending,
                                     r_reg.lin_err,
                                     r_reg.retry_state_flag,
                                     r_reg.supply_reset_flag,
                                     r_reg.thermal_shutdown_flag,
                                     r_reg.temp_warning_flag,
                                     r_reg.led_fault_code};
            3'h3:    r_next.rdata = {29'h0000_0000, r_reg.irq_status};
            3'h4:    r_next.rdata = {29'h0000_0000, r_reg.irq_mask};
            default: r_next.rdata = 32'h0000_0000;
         endcase
      end
      if (apb_wr && idx == 3'h1) begin
         r_next.config_bits = pwdata & 32'h0001_FF3F;
      end
      if (apb_wr && idx == 3'h4) begin
         r_next.irq_mask = pwdata[2:0];
      end
      // write-one-to-clear; a new event in the same cycle survives
      r_next.irq_status = r_reg.irq_status
                          & ~((apb_wr && idx == 3'h3) ? pwdata[2:0] : 3'h0);
      r_next.irq_status = r_next.irq_status | irq_set;
   end

   // ce low freezes every register here and in the memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg             <= '0;
         r_reg.state       <= lfs_pkg::ST_IDLE;
         r_reg.config_bits <= lfs_pkg::CONFIG_RESET;
         r_reg.irq_status  <= lfs_pkg::IRQ_RESET;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // a frozen block must not complete bus transfers it cannot store
   assign pready   = ce;
   // unmapped offsets answer with an error and change nothing
   assign pslverr  = psel && penable && (reg_index(paddr) == 3'h0);
   assign prdata   = r_reg.rdata;
   // level output, so an event masked at first is not lost
   assign irq      = |(r_reg.irq_status & r_reg.irq_mask);
   assign tx_valid = (r_reg.state == lfs_pkg::ST_OUT)
                     || (r_reg.state == lfs_pkg::ST_CKOUT);
   assign tx_data  = r_reg.tx_data;

endmodule : lfs_responder

// [verification/lfs_responder_sva.sv]
module lfs_responder_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        rx_id_valid,
   input wire logic [7:0]  rx_byte,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [7:0]  tx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       mapped;
   logic       acc;
   logic [5:0] node_reg;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
   assign acc = psel && penable;
   // shadow of the programmed node address, to know what byte one holds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         node_reg <= 6'h00;
      end else if (acc && pready && pwrite && paddr == 8'h00) begin
         node_reg <= pwdata[5:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence resp_start;
      ce && rx_id_valid && rx_byte == lfs_pkg::RESP_ID;
   endsequence
   sequence hs;
      tx_valid && tx_ready;
   endsequence
   a_pready_ce: assert property (pready == ce)
      else $error("pready does not follow ce");
   a_slverr_map: assert property (acc |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   a_unmapped_zero: assert property (acc && !pwrite && !mapped |->
      prdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_prdata_hold: assert property (acc && pready |=> $stable(prdata))
      else $error("read data moved after access");
   a_irq_masked: assert property (acc && pready && pwrite &&
      paddr == 8'h0C && pwdata[2:0] == 3'h0 |-> ##2 !irq)
      else $error("irq high with all masked");
   a_tx_hold: assert property (tx_valid && !tx_ready && !rx_id_valid
      |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
   a_tx_cause: assert property ($rose(tx_valid) |-> $past(rx_id_valid, 3)
      || $past(tx_valid && tx_ready, 3) || $past(tx_valid && tx_ready))
      else $error("tx_valid rose without cause");
   a_first_byte: assert property (resp_start ##3 tx_valid |->
      tx_data == {lfs_pkg::ADDR_TOP, node_reg}) else $error("byte one wrong");
   a_second_byte: assert property (resp_start ##3 hs |-> ##3
      (tx_valid && tx_data == lfs_pkg::FILLER)) else $error("byte two wrong");
   a_third_top: assert property (resp_start ##3 hs ##3 hs |-> ##3
      (tx_valid && tx_data[7:3] == 5'h1F)) else $error("byte three wrong");
endmodule : lfs_responder_sva

bind lfs_responder lfs_responder_sva lfs_responder_sva_inst (.pclk, .presetn,
   .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .irq, .rx_id_valid, .rx_byte, .tx_valid, .tx_ready, .tx_data);

// [verification/lfs_lin_master.sv]
module lfs_lin_master (
   input  wire logic       pclk,
   input  wire logic       slow,
   output logic            rx_id_valid,
   output logic            rx_byte_valid,
   output logic      [7:0] rx_byte,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] resp_q[$];
   initial begin
      rx_id_valid = 1'b0;
      rx_byte_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end
   // slow mode takes a byte only every other cycle
   always @(posedge pclk) begin
      tx_ready <= !slow || !tx_ready;
      if (tx_valid && tx_ready) resp_q.push_back(tx_data);
   end
   function automatic logic [7:0] cks(input logic [63:0] d);
      logic [8:0] s;
      s = 9'h000;
      for (int i = 0; i < 8; i++) begin
         s = {1'b0, s[7:0]} + {1'b0, d[8*i +: 8]};
         s = {1'b0, s[7:0]} + {8'h00, s[8]};
      end
      return ~s[7:0];
   endfunction : cks
   task automatic put(input logic id, input logic [7:0] b);
      @(posedge pclk);
      rx_id_valid <= id;
      rx_byte_valid <= !id;
      rx_byte <= b;
   endtask : put
   // released line shows the inverse, never a stale copy
   task automatic idle();
      @(posedge pclk);
      rx_id_valid <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask : idle
   task automatic request(input logic [5:0] a, input logic [7:0] flip);
      logic [63:0] d;
      d = {lfs_pkg::APP_CMD, lfs_pkg::FULL_STATUS_CMD, lfs_pkg::ADDR_TOP, a,
           {5{lfs_pkg::FILLER}}};
      put(1'b1, lfs_pkg::REQ_ID);
      for (int i = 7; i >= 0; i--) put(1'b0, d[8*i +: 8]);
      put(1'b0, cks(d) ^ flip);
      idle();
   endtask : request
   task automatic fetch();
      resp_q.delete();
      put(1'b1, lfs_pkg::RESP_ID);
      idle();
   endtask : fetch
endmodule : lfs_lin_master

// [verification/lfs_responder_tb.sv]
module lfs_responder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr, rx_byte, tx_data;
   logic [31:0] pwdata, prdata, rdv;
   logic        rx_id_valid, rx_byte_valid, tx_valid, tx_ready, slow, errv;
   logic        temp_warning_cond, thermal_shutdown_cond, supply_reset_event;
   logic        retry_state_cond, undervoltage, checksum_err, stopbit_err;
   logic        length_err, parity_err, sync_err, bit_err;
   logic [1:0]  temp_info;
   logic [3:0]  thermal_derating_level;
   logic [8:0]  led_fault_cond;
   int          fail_count, compares;
   lfs_responder lfs_responder_inst (.pclk, .presetn, .ce, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .rx_id_valid,
      .rx_byte_valid, .rx_byte, .tx_valid, .tx_ready, .tx_data,
      .temp_warning_cond, .thermal_shutdown_cond, .supply_reset_event,
      .retry_state_cond, .undervoltage, .temp_info, .thermal_derating_level,
      .led_fault_cond, .checksum_err, .stopbit_err, .length_err, .parity_err,
      .sync_err, .bit_err);
   lfs_lin_master lfs_lin_master_inst (.pclk, .slow, .rx_id_valid,
      .rx_byte_valid, .rx_byte, .tx_valid, .tx_ready, .tx_data);
   always #20 pclk = ~pclk;
   task automatic results();
      if (fail_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         $display("ERROR %0t apb transfer never answered", $time);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdv, exp);
   endtask : rdc
   task automatic resp(input logic [63:0] e);
      int n;
      n = 0;
      while (lfs_lin_master_inst.resp_q.size() < 9 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      for (int i = 0; i < 8; i++) begin
         chk({24'h0, lfs_lin_master_inst.resp_q[i]},
             {24'h0, e[63-8*i -: 8]});
      end
      chk({24'h0, lfs_lin_master_inst.resp_q[8]},
          {24'h0, lfs_lin_master_inst.cks(e)});
   endtask : resp
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      $display("ERROR %0t watchdog expired", $time);
      results();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, slow, checksum_err} = 7'h00;
      {temp_warning_cond, thermal_shutdown_cond, supply_reset_event} = 3'h0;
      {retry_state_cond, stopbit_err, length_err, parity_err} = 4'h0;
      {sync_err, bit_err, led_fault_cond} = 11'h000;
      {ce, undervoltage, temp_info, thermal_derating_level} = 8'hE9;
      {paddr, pwdata, fail_count, compares} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h00, lfs_pkg::CONFIG_RESET);
      rdc(8'h08, 32'h0000_0000);
      rdc(8'h0C, 32'h0000_0000);
      rdc(8'h10, 32'h0000_0000);
      chk({31'h0, errv}, 32'h0000_0001);
      @(posedge pclk);
      ce <= 1'b0;
      fork
         apb(1'b1, 8'h00, 32'h0001_BA15);
         begin
            repeat (4) @(posedge pclk);
            ce <= 1'b1;
         end
      join
      rdc(8'h00, 32'h0001_BA15);
      apb(1'b1, 8'h0C, 32'h0000_0007);
      @(posedge pclk);
      {temp_warning_cond, thermal_shutdown_cond, supply_reset_event,
       retry_state_cond, stopbit_err, sync_err, bit_err} <= 7'h7F;
      led_fault_cond <= {lfs_pkg::FAULT_OPEN_ANODE, lfs_pkg::FAULT_OPEN_CATH,
                         lfs_pkg::FAULT_SHORT_GND};
      @(posedge pclk);
      {temp_warning_cond, thermal_shutdown_cond, supply_reset_event,
       retry_state_cond, stopbit_err, sync_err, bit_err} <= 7'h00;
      led_fault_cond <= {lfs_pkg::FAULT_NONE, lfs_pkg::FAULT_NONE,
                         lfs_pkg::FAULT_SHORT_GND};
      lfs_lin_master_inst.request(6'h16, 8'h00);
      rdc(8'h08, 32'h0000_0000);
      lfs_lin_master_inst.request(6'h15, 8'h01);
      rdc(8'h08, 32'h0000_0002);
      apb(1'b1, 8'h08, 32'h0000_0002);
      rdc(8'h08, 32'h0000_0000);
      lfs_lin_master_inst.request(6'h15, 8'h00);
      rdc(8'h08, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      repeat (10) @(posedge pclk);
      lfs_lin_master_inst.fetch();
      resp(64'hD5FF_FFFE_9ABD_BAFF);
      rdc(8'h08, 32'h0000_0005);
      rdc(8'h04, 32'h0000_0002);
      apb(1'b1, 8'h0C, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'h0000_0005);
      rdc(8'h08, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_BA15);
      {length_err, parity_err} <= 2'h3;
      @(posedge pclk);
      {length_err, parity_err} <= 2'h0;
      slow <= 1'b1;
      lfs_lin_master_inst.request(6'h15, 8'h00);
      repeat (10) @(posedge pclk);
      lfs_lin_master_inst.fetch();
      resp(64'hD5FF_FEE2_F288_BAFF);
      results();
   end
endmodule : lfs_responder_tb
